/* rtl/wec_top.sv */
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Count register low byte holds events, resets zero.
// RULE_02: Clearing the wakeup interrupt also clears count.
// RULE_03: Any write to count-clear zeroes the counter.
// RULE_04: Port 0 inputs each have an enable bit.
// RULE_05: Port 1 inputs each have an enable bit.
// RULE_06: Port 2 inputs each have an enable bit.
// RULE_07: Port 3 inputs each have an enable bit.
// RULE_08: Port 0 polarity picks rising or falling edge.
// RULE_09: Port 1 polarity picks rising or falling edge.
// RULE_10: Port 2 polarity picks rising or falling edge.
// RULE_11: Port 3 polarity picks rising or falling edge.
// RULE_12: Enabled interrupt fires when count reaches compare.
// RULE_13: Debounce 1 to 63 ms, zero disables.
// RULE_14: Software key hit counts once; rearm by clearing.
// RULE_15: Any write to interrupt-reset clears it; reads zero.
// RULE_16: Inputs synchronised; disabled inputs never count.
// RULE_17: Reserved bits read zero, writes ignored.
module wec_top #(
  parameter int CYC_PER_MS = wec_pkg::CYC_PER_MS,
  parameter int P0_W = wec_pkg::P0_W,
  parameter int P1_W = wec_pkg::P1_W,
  parameter int P2_W = wec_pkg::P2_W,
  parameter int P3_W = wec_pkg::P3_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [wec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [P0_W-1:0] gpio_p0_i,
  input wire logic [P1_W-1:0] gpio_p1_i,
  input wire logic [P2_W-1:0] gpio_p2_i,
  input wire logic [P3_W-1:0] gpio_p3_i,
  output logic irq_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int MS_W = $clog2(CYC_PER_MS + 1);

  logic aw_hold_reg;
  logic w_hold_reg;
  logic [wec_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_fire, rd_fire, wr_hit, rd_hit;
  logic [31:0] rd_val;
  logic [15:0] wmask;

  logic match_irq_en_reg;
  logic key_hit_reg;
  logic [wec_pkg::DEB_W-1:0] deb_ms_reg;
  logic [wec_pkg::CNT_W-1:0] compare_reg;
  logic [wec_pkg::CNT_W-1:0] count_reg;
  logic [wec_pkg::CNT_W-1:0] count_next;
  logic [P0_W-1:0] en_p0_reg;
  logic [P1_W-1:0] en_p1_reg;
  logic [P2_W-1:0] en_p2_reg;
  logic [P3_W-1:0] en_p3_reg;
  logic [P0_W-1:0] pol_p0_reg;
  logic [P1_W-1:0] pol_p1_reg;
  logic [P2_W-1:0] pol_p2_reg;
  logic [P3_W-1:0] pol_p3_reg;
  logic irq_stat_reg;
  logic irq_mask_reg;
  logic [MS_W-1:0] ms_cnt_reg;
  logic ms_tick;

  logic [P0_W-1:0] rise_p0, fall_p0;
  logic [P1_W-1:0] rise_p1, fall_p1;
  logic [P2_W-1:0] rise_p2, fall_p2;
  logic [P3_W-1:0] rise_p3, fall_p3;
  logic key_rise, event_hit, cnt_clr, irq_clr, match_evt;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data accepted in either order, one write in flight
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= wec_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? wec_pkg::RESP_OKAY : wec_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Mapped words fill an 8-byte stride from control up to mask
  assign wr_hit = (aw_addr_reg >= wec_pkg::badr(wec_pkg::IDX_CTRL)) && (aw_addr_reg[2:0] == 3'h0)
                  && (aw_addr_reg <= wec_pkg::badr(wec_pkg::IDX_IRQ_MASK));

  // Byte lanes 0 and 1 carry the 16-bit registers
  assign wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  // Strobe registers: any write, data ignored
  assign cnt_clr = wr_fire && (aw_addr_reg == wec_pkg::badr(wec_pkg::IDX_CNT_CLR)); // [RULE_03]
  assign irq_clr = wr_fire && (aw_addr_reg == wec_pkg::badr(wec_pkg::IDX_IRQ_CLR)); // [RULE_15]

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Reserved bits are never stored, so they read back as zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_irq_en_reg <= 1'b0;
      key_hit_reg <= 1'b0;
      deb_ms_reg <= '0;
      compare_reg <= '0;
      irq_mask_reg <= 1'b0;
    end else if (wr_fire && w_strb_reg[0]) begin
      case (aw_addr_reg)
        wec_pkg::badr(wec_pkg::IDX_CTRL): begin
          match_irq_en_reg <= w_data_reg[wec_pkg::CTRL_IRQ_EN_BIT];
          key_hit_reg <= w_data_reg[wec_pkg::CTRL_KEY_HIT_BIT];
          deb_ms_reg <= w_data_reg[wec_pkg::DEB_W-1:0]; // [RULE_17]
        end
        wec_pkg::badr(wec_pkg::IDX_COMPARE): compare_reg <= w_data_reg[wec_pkg::CNT_W-1:0];
        wec_pkg::badr(wec_pkg::IDX_IRQ_MASK): irq_mask_reg <= w_data_reg[wec_pkg::IRQ_MATCH_BIT];
        default: ;
      endcase
    end
  end

  // Enable and polarity registers per port
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_p0_reg <= '0;
      en_p1_reg <= '0;
      en_p2_reg <= '0;
      en_p3_reg <= '0;
      pol_p0_reg <= '0;
      pol_p1_reg <= '0;
      pol_p2_reg <= '0;
      pol_p3_reg <= '0;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        wec_pkg::badr(wec_pkg::IDX_SEL_P0):
          en_p0_reg <= (en_p0_reg & ~wmask[P0_W-1:0]) | (w_data_reg[P0_W-1:0] & wmask[P0_W-1:0]); // [RULE_04]
        wec_pkg::badr(wec_pkg::IDX_SEL_P1):
          en_p1_reg <= (en_p1_reg & ~wmask[P1_W-1:0]) | (w_data_reg[P1_W-1:0] & wmask[P1_W-1:0]); // [RULE_05]
        wec_pkg::badr(wec_pkg::IDX_SEL_P2):
          en_p2_reg <= (en_p2_reg & ~wmask[P2_W-1:0]) | (w_data_reg[P2_W-1:0] & wmask[P2_W-1:0]); // [RULE_06]
        wec_pkg::badr(wec_pkg::IDX_SEL_P3):
          en_p3_reg <= (en_p3_reg & ~wmask[P3_W-1:0]) | (w_data_reg[P3_W-1:0] & wmask[P3_W-1:0]); // [RULE_07]
        wec_pkg::badr(wec_pkg::IDX_POL_P0):
          pol_p0_reg <= (pol_p0_reg & ~wmask[P0_W-1:0]) | (w_data_reg[P0_W-1:0] & wmask[P0_W-1:0]);
        wec_pkg::badr(wec_pkg::IDX_POL_P1):
          pol_p1_reg <= (pol_p1_reg & ~wmask[P1_W-1:0]) | (w_data_reg[P1_W-1:0] & wmask[P1_W-1:0]);
        wec_pkg::badr(wec_pkg::IDX_POL_P2):
          pol_p2_reg <= (pol_p2_reg & ~wmask[P2_W-1:0]) | (w_data_reg[P2_W-1:0] & wmask[P2_W-1:0]);
        wec_pkg::badr(wec_pkg::IDX_POL_P3):
          pol_p3_reg <= (pol_p3_reg & ~wmask[P3_W-1:0]) | (w_data_reg[P3_W-1:0] & wmask[P3_W-1:0]);
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Millisecond tick and input filters
  // ****************************************************************
  // Free-running divider; first debounce tick may come early by under 1 ms
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_reg <= '0;
    end else if (ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end

  assign ms_tick = (ms_cnt_reg == MS_W'(CYC_PER_MS - 1));

  wec_filter #(.WIDTH(P0_W)) u_filt_p0 (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .raw_i(gpio_p0_i), .deb_ms_i(deb_ms_reg),
    .ms_tick_i(ms_tick), .rise_o(rise_p0), .fall_o(fall_p0)
  );
  wec_filter #(.WIDTH(P1_W)) u_filt_p1 (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .raw_i(gpio_p1_i), .deb_ms_i(deb_ms_reg),
    .ms_tick_i(ms_tick), .rise_o(rise_p1), .fall_o(fall_p1)
  );
  wec_filter #(.WIDTH(P2_W)) u_filt_p2 (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .raw_i(gpio_p2_i), .deb_ms_i(deb_ms_reg),
    .ms_tick_i(ms_tick), .rise_o(rise_p2), .fall_o(fall_p2)
  );
  wec_filter #(.WIDTH(P3_W)) u_filt_p3 (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .raw_i(gpio_p3_i), .deb_ms_i(deb_ms_reg),
    .ms_tick_i(ms_tick), .rise_o(rise_p3), .fall_o(fall_p3)
  );
  // Software key hit passes the same debounce as a pin
  wec_filter #(.WIDTH(1)) u_filt_key (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .raw_i(key_hit_reg), .deb_ms_i(deb_ms_reg),
    .ms_tick_i(ms_tick), .rise_o(key_rise), .fall_o()
  ); // [RULE_14]

  // ****************************************************************
  // Event counter and compare
  // ****************************************************************
  // Polarity 0 counts rising, 1 counts falling; disabled pins masked
  assign event_hit = |(en_p0_reg & ((~pol_p0_reg & rise_p0) | (pol_p0_reg & fall_p0))) // [RULE_08]
                   | |(en_p1_reg & ((~pol_p1_reg & rise_p1) | (pol_p1_reg & fall_p1))) // [RULE_09]
                   | |(en_p2_reg & ((~pol_p2_reg & rise_p2) | (pol_p2_reg & fall_p2))) // [RULE_10]
                   | |(en_p3_reg & ((~pol_p3_reg & rise_p3) | (pol_p3_reg & fall_p3))) // [RULE_11]
                   | key_rise; // [RULE_16]

  // Several edges in one cycle count once; clearing beats counting
  always_comb begin
    if (cnt_clr || irq_clr) begin
      count_next = '0; // [RULE_02] [RULE_03]
    end else if (event_hit) begin
      count_next = count_reg + 1'b1;
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= '0; // [RULE_01]
    end else begin
      count_reg <= count_next;
    end
  end

  // Match taken on the increment that lands on the compare value
  assign match_evt = match_irq_en_reg && event_hit && !(cnt_clr || irq_clr)
                     && (count_next == compare_reg); // [RULE_12]

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // Sticky; a new match wins over a write-one clear of the status, while an interrupt-reset write blocks the match
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= 1'b0;
    end else if (match_evt) begin
      irq_stat_reg <= 1'b1; // [RULE_12]
    end else if (irq_clr) begin
      irq_stat_reg <= 1'b0; // [RULE_15]
    end else if (wr_fire && w_strb_reg[0] && w_data_reg[wec_pkg::IRQ_MATCH_BIT]
                 && aw_addr_reg == wec_pkg::badr(wec_pkg::IDX_IRQ_STAT)) begin
      irq_stat_reg <= 1'b0;
    end
  end

  assign irq_o = irq_stat_reg & irq_mask_reg;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = ~rvalid_reg;
  assign rd_fire = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Read mux; strobe registers answer zero
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      wec_pkg::badr(wec_pkg::IDX_CTRL): begin
        rd_val[wec_pkg::CTRL_IRQ_EN_BIT] = match_irq_en_reg;
        rd_val[wec_pkg::CTRL_KEY_HIT_BIT] = key_hit_reg;
        rd_val[wec_pkg::DEB_W-1:0] = deb_ms_reg;
      end
      wec_pkg::badr(wec_pkg::IDX_COMPARE): rd_val[wec_pkg::CNT_W-1:0] = compare_reg;
      wec_pkg::badr(wec_pkg::IDX_COUNT): rd_val[wec_pkg::CNT_W-1:0] = count_reg; // [RULE_01]
      wec_pkg::badr(wec_pkg::IDX_IRQ_CLR), wec_pkg::badr(wec_pkg::IDX_CNT_CLR): rd_val = '0; // [RULE_15]
      wec_pkg::badr(wec_pkg::IDX_SEL_P0): rd_val[P0_W-1:0] = en_p0_reg;
      wec_pkg::badr(wec_pkg::IDX_SEL_P1): rd_val[P1_W-1:0] = en_p1_reg;
      wec_pkg::badr(wec_pkg::IDX_SEL_P2): rd_val[P2_W-1:0] = en_p2_reg;
      wec_pkg::badr(wec_pkg::IDX_SEL_P3): rd_val[P3_W-1:0] = en_p3_reg;
      wec_pkg::badr(wec_pkg::IDX_POL_P0): rd_val[P0_W-1:0] = pol_p0_reg;
      wec_pkg::badr(wec_pkg::IDX_POL_P1): rd_val[P1_W-1:0] = pol_p1_reg;
      wec_pkg::badr(wec_pkg::IDX_POL_P2): rd_val[P2_W-1:0] = pol_p2_reg;
      wec_pkg::badr(wec_pkg::IDX_POL_P3): rd_val[P3_W-1:0] = pol_p3_reg;
      wec_pkg::badr(wec_pkg::IDX_IRQ_STAT): rd_val[wec_pkg::IRQ_MATCH_BIT] = irq_stat_reg;
      wec_pkg::badr(wec_pkg::IDX_IRQ_MASK): rd_val[wec_pkg::IRQ_MATCH_BIT] = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Data registered at acceptance, held until taken
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= wec_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val; // [RULE_17]
      rresp_reg <= rd_hit ? wec_pkg::RESP_OKAY : wec_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : wec_top

/* pkg/wec_pkg.sv */
package wec_pkg;

  // ****************************************************************
  // Register map: printed offsets are register indices
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [31:0] IDX_CTRL = 32'h5000_0100;
  localparam logic [31:0] IDX_COMPARE = 32'h5000_0102;
  localparam logic [31:0] IDX_IRQ_CLR = 32'h5000_0104;
  localparam logic [31:0] IDX_COUNT = 32'h5000_0106;
  localparam logic [31:0] IDX_CNT_CLR = 32'h5000_0108;
  localparam logic [31:0] IDX_SEL_P0 = 32'h5000_010A;
  localparam logic [31:0] IDX_SEL_P1 = 32'h5000_010C;
  localparam logic [31:0] IDX_SEL_P2 = 32'h5000_010E;
  localparam logic [31:0] IDX_SEL_P3 = 32'h5000_0110;
  localparam logic [31:0] IDX_POL_P0 = 32'h5000_0112;
  localparam logic [31:0] IDX_POL_P1 = 32'h5000_0114;
  localparam logic [31:0] IDX_POL_P2 = 32'h5000_0116;
  localparam logic [31:0] IDX_POL_P3 = 32'h5000_0118;
  localparam logic [31:0] IDX_IRQ_STAT = 32'h5000_011A;
  localparam logic [31:0] IDX_IRQ_MASK = 32'h5000_011C;

  // Byte address inside the window is four times the low index bits
  function automatic logic [ADDR_W-1:0] badr(input logic [31:0] idx);
    return {idx[9:0], 2'h0};
  endfunction : badr

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int P0_W = 8;
  localparam int P1_W = 6;
  localparam int P2_W = 10;
  localparam int P3_W = 8;
  localparam int CNT_W = 8;
  localparam int DEB_W = 6;
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_KEY_HIT_BIT = 6;
  localparam int IRQ_MATCH_BIT = 0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEB_UNIT_NS = 1000000;
  localparam int CYC_PER_MS = (DEB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : wec_pkg

/* rtl/wec_filter.sv */
`timescale 1ns/1ps
// Synchroniser, debounce filter and edge detector for a group of inputs
module wec_filter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] raw_i,
  input wire logic [wec_pkg::DEB_W-1:0] deb_ms_i,
  input wire logic ms_tick_i,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_d_reg;
  logic [wec_pkg::DEB_W-1:0] stab_reg [WIDTH];

  // Two-stage synchroniser; resets to the pulled-up idle level so no false edge follows reset on inputs that idle high
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= raw_i;
      sync_reg <= meta_reg; // [RULE_16]
    end
  end

  // Level accepted only after N ms ticks of stability
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= '1;
      for (int i = 0; i < WIDTH; i++) begin
        stab_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (deb_ms_i == '0) begin
          level_reg[i] <= sync_reg[i]; // [RULE_13]
          stab_reg[i] <= '0;
        end else if (sync_reg[i] == level_reg[i]) begin
          stab_reg[i] <= '0; // Bounce restarts the wait
        end else if (ms_tick_i) begin
          if (stab_reg[i] + 1'b1 >= deb_ms_i) begin
            level_reg[i] <= sync_reg[i]; // [RULE_13]
            stab_reg[i] <= '0;
          end else begin
            stab_reg[i] <= stab_reg[i] + 1'b1;
          end
        end
      end
    end
  end

  // Edge detection on the filtered level
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_d_reg <= '1;
    end else begin
      level_d_reg <= level_reg;
    end
  end

  assign rise_o = level_reg & ~level_d_reg;
  assign fall_o = ~level_reg & level_d_reg;

endmodule : wec_filter

/* verif/wec_checker.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus handshake and interrupt checks
// ****************************************************************
module wec_checker (
  input logic clk_sys_i,
  input logic rst_n_i,
  input logic [wec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [wec_pkg::ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic ar_go;
  logic wr_go;
  // Accepted requests; our master offers address and data together
  assign ar_go = s_axi_arvalid && s_axi_arready;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_gate; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_gate: assert property (p_ar_gate) else $error("read taken while answer pending");
  property p_w_gate; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_gate: assert property (p_w_gate) else $error("write taken while response pending");
  property p_rd_lat; ar_go |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat; wr_go |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_clr_zero; ar_go && s_axi_araddr == wec_pkg::badr(wec_pkg::IDX_IRQ_CLR) |=> s_axi_rdata == 32'h0; endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("interrupt clear read not zero");
  property p_cnt_rsvd; ar_go && s_axi_araddr == wec_pkg::badr(wec_pkg::IDX_COUNT) |=> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("count upper bits not zero");
  property p_irq_clr; wr_go && s_axi_awaddr == wec_pkg::badr(wec_pkg::IDX_IRQ_CLR) |-> ##2 !irq_o; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt survived clear");
  property p_bad_rd; ar_go && s_axi_araddr == 12'h000 |=> s_axi_rresp == wec_pkg::RESP_SLVERR; endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
  c_wr: cover property (wr_go);
  c_rd: cover property (ar_go);
  c_irq: cover property ($rose(irq_o));
endmodule : wec_checker

/* verif/wec_key_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Keys with pull-ups: pressed pulls low, may chatter
// ****************************************************************
module wec_key_model (
  input wire logic clk_sys_i,
  input wire logic bounce_i,
  input wire logic [31:0] press_i,
  output logic [31:0] pins_o
);
  logic [31:0] last_reg = 32'h0;
  logic [31:0] chg_reg = 32'h0;
  logic [3:0] chat_reg = 4'h0;
  // Contact chatter on changed keys, so debounce has work to do
  always_ff @(posedge clk_sys_i) begin
    last_reg <= press_i;
    if (bounce_i && press_i != last_reg) begin
      chat_reg <= 4'h8;
      chg_reg <= press_i ^ last_reg;
    end else if (chat_reg != 4'h0) chat_reg <= chat_reg - 4'h1;
  end
  // Released key reads high through its pull-up
  assign pins_o = ~press_i ^ (chat_reg[0] ? chg_reg : 32'h0);
endmodule : wec_key_model

/* verif/testbench.sv */
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, press = 32'h0, v, pins;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, bounce = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic [7:0] gpio_p0_i, gpio_p3_i;
  logic [5:0] gpio_p1_i;
  logic [9:0] gpio_p2_i;
  int mismatches = 0, n_checks = 0, cyc = 0;
  localparam int WID[4] = '{8, 6, 10, 8};
  localparam int OFS[4] = '{0, 8, 14, 24};
  // Short ms so debounce fits the run
  wec_top #(.CYC_PER_MS(10)) dut (.*);
  wec_key_model keys (.clk_sys_i(clk_sys_i), .bounce_i(bounce), .press_i(press), .pins_o(pins));
  assign {gpio_p3_i, gpio_p2_i, gpio_p1_i, gpio_p0_i} = pins;
  always #20 clk_sys_i = ~clk_sys_i;
  // Hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Response raised late so the slave must hold its answer
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    @(posedge clk_sys_i);
    s_axi_awaddr <= wec_pkg::badr(idx);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys_i);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] idx, output logic [31:0] d);
    @(posedge clk_sys_i);
    s_axi_araddr <= wec_pkg::badr(idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [31:0] idx, input logic [31:0] exp);
    rd(idx, v);
    chk(v, exp);
  endtask : rc
  task automatic hit(input logic [31:0] en);
    wr(wec_pkg::IDX_CTRL, en | 32'h40);
    wr(wec_pkg::IDX_CTRL, en);
    repeat (8) @(posedge clk_sys_i);
  endtask : hit
  task automatic t_regs();
    for (int p = 0; p < 4; p++) begin
      rc(wec_pkg::IDX_SEL_P0 + 2 * p, 32'h0);
      wr(wec_pkg::IDX_SEL_P0 + 2 * p, 32'hFFFF_FFFF);
      rc(wec_pkg::IDX_SEL_P0 + 2 * p, (32'h1 << WID[p]) - 1);
      wr(wec_pkg::IDX_POL_P0 + 2 * p, 32'hFFFF_FFFF);
      rc(wec_pkg::IDX_POL_P0 + 2 * p, (32'h1 << WID[p]) - 1);
      wr(wec_pkg::IDX_SEL_P0 + 2 * p, 32'h0);
    end
    wr(wec_pkg::IDX_COUNT, 32'hFF);
    chk(resp, wec_pkg::RESP_OKAY);
    rc(wec_pkg::IDX_COUNT, 32'h0);
    rc(wec_pkg::IDX_IRQ_CLR, 32'h0);
    rd(32'h0, v);
    chk(resp, wec_pkg::RESP_SLVERR);
    wr(32'h0, 32'h0);
    chk(resp, wec_pkg::RESP_SLVERR);
  endtask : t_regs
  // Top pin enabled, pin 0 pressed too but left disabled
  task automatic t_edges();
    for (int p = 0; p < 4; p++) begin
      wr(wec_pkg::IDX_SEL_P0 + 2 * p, 32'h1 << (WID[p] - 1));
      for (int pol = 1; pol >= 0; pol--) begin
        wr(wec_pkg::IDX_POL_P0 + 2 * p, pol << (WID[p] - 1));
        wr(wec_pkg::IDX_CNT_CLR, 32'hA5);
        rc(wec_pkg::IDX_COUNT, 32'h0);
        press <= (32'h1 << OFS[p]) | (32'h1 << (OFS[p] + WID[p] - 1));
        repeat (8) @(posedge clk_sys_i);
        rc(wec_pkg::IDX_COUNT, pol);
        press <= 32'h0;
        repeat (8) @(posedge clk_sys_i);
        rc(wec_pkg::IDX_COUNT, 32'h1);
      end
      wr(wec_pkg::IDX_SEL_P0 + 2 * p, 32'h0);
    end
  endtask : t_edges
  task automatic t_irq();
    wr(wec_pkg::IDX_CNT_CLR, 32'h0);
    wr(wec_pkg::IDX_COMPARE, 32'h2);
    wr(wec_pkg::IDX_IRQ_MASK, 32'h1);
    hit(32'h80);
    chk(irq_o, 1'b0);
    hit(32'h80);
    chk(irq_o, 1'b1);
    rc(wec_pkg::IDX_COUNT, 32'h2);
    rc(wec_pkg::IDX_IRQ_STAT, 32'h1);
    wr(wec_pkg::IDX_IRQ_MASK, 32'h0);
    chk(irq_o, 1'b0);
    wr(wec_pkg::IDX_IRQ_MASK, 32'h1);
    chk(irq_o, 1'b1);
    wr(wec_pkg::IDX_IRQ_STAT, 32'h1);
    chk(irq_o, 1'b0);
    wr(wec_pkg::IDX_COMPARE, 32'h3);
    hit(32'h80);
    chk(irq_o, 1'b1);
    wr(wec_pkg::IDX_IRQ_CLR, 32'h0);
    chk(irq_o, 1'b0);
    rc(wec_pkg::IDX_COUNT, 32'h0);
    wr(wec_pkg::IDX_COMPARE, 32'h1);
    hit(32'h0);
    rc(wec_pkg::IDX_COUNT, 32'h1);
    chk(irq_o, 1'b0);
  endtask : t_irq
  // Chattering press with 3 ms debounce counts once, not early
  task automatic t_deb();
    wr(wec_pkg::IDX_CNT_CLR, 32'h0);
    wr(wec_pkg::IDX_SEL_P1, 32'h1);
    wr(wec_pkg::IDX_POL_P1, 32'h1);
    wr(wec_pkg::IDX_CTRL, 32'h3);
    bounce <= 1'b1;
    press <= 32'h100;
    repeat (12) @(posedge clk_sys_i);
    rc(wec_pkg::IDX_COUNT, 32'h0);
    repeat (40) @(posedge clk_sys_i);
    rc(wec_pkg::IDX_COUNT, 32'h1);
  endtask : t_deb
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk(irq_o, 1'b0);
    t_regs();
    t_edges();
    t_irq();
    t_deb();
    results();
  end
endmodule : testbench
bind wec_top wec_checker u_chk (.*);
